/* rtl/dlts_pkg.sv */
// dlts_pkg: constants shared by the delay-line read tuning sequencer
// assumes ratios of 0..124, temperature as signed whole degrees celsius
package dlts_pkg;

  // ------------------------------------------------------------------
  // ratio range and sweep
  // ------------------------------------------------------------------
  localparam logic [6:0] RATIO_MAX     = 7'h7C;  // highest ratio element, 124
  localparam logic [6:0] COARSE_STEP   = 7'h04;  // coarse increment
  localparam int         COARSE_PTS    = 32;     // 0,4,..,124
  localparam logic [5:0] COARSE_LAST   = 6'h1F;  // last coarse index
  localparam logic [6:0] FINE_SPAN     = 7'h0A;  // single steps each side
  localparam logic [6:0] SKIP_BELOW    = 7'h28;  // 40: no re-timing search
  localparam logic [6:0] COLD_BACKOFF  = 7'h18;  // 24 below largest pass
  localparam logic [3:0] MARGIN_RST    = 4'h8;   // default downward margin

  // ------------------------------------------------------------------
  // control word layout
  // ------------------------------------------------------------------
  localparam int         FRC_LSB       = 13;     // forced ratio field [19:13]
  localparam int         FRC_MSB       = 19;

  // ------------------------------------------------------------------
  // temperature bands (degrees celsius)
  // ------------------------------------------------------------------
  localparam logic signed [9:0] T_M20  = -10'sd20;
  localparam logic signed [9:0] T_10   = 10'sd10;
  localparam logic signed [9:0] T_20   = 10'sd20;
  localparam logic signed [9:0] T_40   = 10'sd40;
  localparam logic signed [9:0] T_70   = 10'sd70;
  localparam logic signed [9:0] T_90   = 10'sd90;
  localparam logic signed [9:0] T_120  = 10'sd120;

  // ------------------------------------------------------------------
  // window fractions in sixteenths and offsets above a low failure
  // ------------------------------------------------------------------
  localparam logic [3:0] FR_COLD = 4'hD;  // 13/16
  localparam logic [3:0] FR_M20  = 4'h9;  // 9/16
  localparam logic [3:0] FR_20   = 4'h8;  // 1/2
  localparam logic [3:0] FR_40   = 4'h7;  // 7/16
  localparam logic [3:0] FR_70   = 4'h5;  // 5/16
  localparam logic [3:0] FR_90   = 4'h4;  // 4/16
  localparam logic [3:0] FR_120  = 4'h3;  // 3/16
  localparam logic [6:0] OFS_12  = 7'h0C;
  localparam logic [6:0] OFS_8   = 7'h08;
  localparam logic [6:0] OFS_10  = 7'h0A;

  // ------------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_CREQ   = 4'h1,
    ST_SCAN   = 4'h2,
    ST_TEMP   = 4'h3,
    ST_CALC   = 4'h4,
    ST_FREQ   = 4'h5,
    ST_FIX    = 4'h6,
    ST_DONE   = 4'h7
  } dlts_state_t;

endpackage

/* rtl/dlts_pass_mem.sv */
// dlts_pass_mem: one pass bit per coarse ratio point
// assumes a single clock; read data leave a register one cycle after address
`timescale 1ns/100ps
module dlts_pass_mem (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // write side
  input  wire logic       wr_en,
  input  wire logic [4:0] wr_addr,
  input  wire logic       wr_bit,
  // read side
  input  wire logic [4:0] rd_addr,
  output logic            rd_bit_r
);

  logic [31:0] bits_r;  // pass map, bit n is ratio 4*n

  // ------------------------------------------------------------------
  // storage and registered read
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bits_r   <= 32'h0000_0000;
      rd_bit_r <= 1'b0;
    end else begin
      if (wr_en) begin
        bits_r[wr_addr] <= wr_bit;
      end
      rd_bit_r <= bits_r[rd_addr];
    end
  end

endmodule

/* rtl/dlts_seq.sv */
// dlts_seq: delay-line read tuning sequencer for the 192 MHz card bus
// assumes a command engine that runs each tuning read and streams the
// returned block beside the expected tuning pattern on the same clock
`timescale 1ns/100ps
module dlts_seq (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // control
  input  wire logic              tune_start,
  input  wire logic [3:0]        retime_margin,
  input  wire logic signed [9:0] temp_c,
  output logic                   tune_busy,
  output logic                   tune_done_r,
  output logic                   tune_fail_r,
  // tuning read command engine
  output logic                   rd_req,
  output logic [6:0]             rd_ratio_r,
  input  wire logic              rd_beat,
  input  wire logic [7:0]        rd_data,
  input  wire logic [7:0]        rd_expect,
  input  wire logic              rd_end,
  input  wire logic              rd_crc_err,
  // delay line
  output logic [31:0]            delay_line_control_register,
  output logic [6:0]             forced_delay_ratio
);

  dlts_pkg::dlts_state_t st_r, st_nxt;  // sequencer state

  logic [5:0]        cidx_r;      // coarse index / scan index
  logic [7:0]        cap_r;       // registered copy of rd_data
  logic [7:0]        exp_r;       // pattern aligned with cap_r
  logic              cap_vld_r;   // cap_r holds a beat
  logic              mism_r;      // mismatch seen in this read
  logic [5:0]        run_st_r;    // current run start index
  logic [5:0]        run_len_r;   // current run length
  logic [5:0]        best_st_r;   // largest window start index
  logic [5:0]        best_len_r;  // largest window length
  logic signed [9:0] temp_r;      // sampled temperature
  logic [6:0]        otv_r;       // optimum tuning value
  logic [6:0]        fend_r;      // last single-step ratio
  logic              fa_r;        // failure above found
  logic [6:0]        fa_rat_r;    // smallest failing ratio above
  logic              fb_r;        // failure below found
  logic [6:0]        fb_rat_r;    // largest failing ratio below
  logic [6:0]        final_r;     // chosen ratio
  logic              mem_q;       // pass bit from scan read

  // ------------------------------------------------------------------
  // read result decode
  // ------------------------------------------------------------------
  wire       beat_bad  = cap_vld_r && (cap_r != exp_r);
  wire       rd_pass   = rd_end && !rd_crc_err && !mism_r && !beat_bad;
  wire       in_coarse = (st_r == dlts_pkg::ST_CREQ);
  wire       in_fine   = (st_r == dlts_pkg::ST_FREQ);
  wire [4:0] pos       = 5'(cidx_r - 6'h01);
  wire       scan_take = (st_r == dlts_pkg::ST_SCAN) && (cidx_r != 6'h00);

  // ------------------------------------------------------------------
  // window math
  // ------------------------------------------------------------------
  wire [6:0]  lpw_lo  = {best_st_r[4:0], 2'b00};
  wire [6:0]  lpw_hi  = 7'({best_st_r + best_len_r - 6'h01, 2'b00});
  wire [6:0]  lpw_w   = lpw_hi - lpw_lo;
  wire        cold    = temp_r < dlts_pkg::T_M20;
  wire [3:0]  frac    = cold                      ? dlts_pkg::FR_COLD :
                        (temp_r < dlts_pkg::T_20)  ? dlts_pkg::FR_M20  :
                        (temp_r < dlts_pkg::T_40)  ? dlts_pkg::FR_20   :
                        (temp_r < dlts_pkg::T_70)  ? dlts_pkg::FR_40   :
                        (temp_r < dlts_pkg::T_90)  ? dlts_pkg::FR_70   :
                        (temp_r < dlts_pkg::T_120) ? dlts_pkg::FR_90   :
                                                     dlts_pkg::FR_120;
  wire [10:0] prod    = 11'(lpw_w) * 11'(frac);
  wire [6:0]  frac_v  = 7'(lpw_lo + 7'((prod + 11'h00F) >> 4));  // ceiling
  wire [6:0]  hi_back = (lpw_hi > dlts_pkg::COLD_BACKOFF) ?
                        7'(lpw_hi - dlts_pkg::COLD_BACKOFF) : 7'h00;
  wire [6:0]  otv_nxt = (cold && hi_back < frac_v) ? hi_back : frac_v;
  wire [6:0]  f_lo    = (otv_nxt > dlts_pkg::FINE_SPAN) ?
                        7'(otv_nxt - dlts_pkg::FINE_SPAN) : 7'h00;
  wire [6:0]  f_hi    = (otv_nxt > 7'(dlts_pkg::RATIO_MAX - dlts_pkg::FINE_SPAN)) ?
                        dlts_pkg::RATIO_MAX : 7'(otv_nxt + dlts_pkg::FINE_SPAN);

  // ------------------------------------------------------------------
  // correction math
  // ------------------------------------------------------------------
  wire [6:0]  ofs     = (temp_r < dlts_pkg::T_10) ? dlts_pkg::OFS_12 :
                        (temp_r < dlts_pkg::T_70) ? dlts_pkg::OFS_8  :
                        (temp_r < dlts_pkg::T_90) ? dlts_pkg::OFS_10 :
                                                    dlts_pkg::OFS_12;
  wire [7:0]  up_a    = 8'(fa_rat_r) + 8'(ofs);
  wire [7:0]  up_b    = 8'(fb_rat_r) + 8'(ofs);
  wire [6:0]  up_a_c  = (up_a > 8'(dlts_pkg::RATIO_MAX)) ? dlts_pkg::RATIO_MAX : up_a[6:0];
  wire [6:0]  up_b_c  = (up_b > 8'(dlts_pkg::RATIO_MAX)) ? dlts_pkg::RATIO_MAX : up_b[6:0];
  wire [6:0]  dn_a    = (fa_rat_r > 7'(retime_margin)) ?
                        7'(fa_rat_r - 7'(retime_margin)) : 7'h00;
  wire [6:0]  fix_v   = fa_r ? (cold ? up_a_c : dn_a) :
                        fb_r ? up_b_c : otv_r;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      dlts_pkg::ST_IDLE: if (tune_start) st_nxt = dlts_pkg::ST_CREQ;
      dlts_pkg::ST_CREQ: if (rd_end && cidx_r == dlts_pkg::COARSE_LAST) st_nxt = dlts_pkg::ST_SCAN;
      dlts_pkg::ST_SCAN: if (cidx_r == 6'(dlts_pkg::COARSE_PTS)) st_nxt = dlts_pkg::ST_TEMP;
      dlts_pkg::ST_TEMP: st_nxt = (best_len_r == 6'h00) ? dlts_pkg::ST_DONE : dlts_pkg::ST_CALC;
      dlts_pkg::ST_CALC: st_nxt = (otv_nxt < dlts_pkg::SKIP_BELOW) ?
                                  dlts_pkg::ST_FIX : dlts_pkg::ST_FREQ;
      dlts_pkg::ST_FREQ: if (rd_end && rd_ratio_r == fend_r) st_nxt = dlts_pkg::ST_FIX;
      dlts_pkg::ST_FIX:  st_nxt = dlts_pkg::ST_DONE;
      dlts_pkg::ST_DONE: if (tune_start) st_nxt = dlts_pkg::ST_CREQ;
      default:           st_nxt = dlts_pkg::ST_IDLE;
    endcase
  end

  assign rd_req    = in_coarse || in_fine;
  assign tune_busy = (st_r != dlts_pkg::ST_IDLE) && (st_r != dlts_pkg::ST_DONE);

  // ------------------------------------------------------------------
  // coarse results storage
  // ------------------------------------------------------------------
  dlts_pass_mem u_mem (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .wr_en    (in_coarse && rd_end),
    .wr_addr  (cidx_r[4:0]),
    .wr_bit   (rd_pass),
    .rd_addr  (cidx_r[4:0]),
    .rd_bit_r (mem_q)
  );

  // ------------------------------------------------------------------
  // state and read capture
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r      <= dlts_pkg::ST_IDLE;
      cap_r     <= 8'h00;
      exp_r     <= 8'h00;
      cap_vld_r <= 1'b0;
      mism_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cap_r     <= rd_data;
      exp_r     <= rd_expect;
      cap_vld_r <= rd_beat && rd_req;
      mism_r    <= rd_end ? 1'b0 : (mism_r || beat_bad);
    end
  end

  // ------------------------------------------------------------------
  // sweep index, ratio and window scan
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cidx_r     <= 6'h00;
      rd_ratio_r <= 7'h00;
      run_st_r   <= 6'h00;
      run_len_r  <= 6'h00;
      best_st_r  <= 6'h00;
      best_len_r <= 6'h00;
    end else if (tune_start && !tune_busy) begin
      cidx_r     <= 6'h00;
      rd_ratio_r <= 7'h00;
      run_len_r  <= 6'h00;
      best_len_r <= 6'h00;
    end else if (in_coarse && rd_end) begin
      cidx_r     <= (cidx_r == dlts_pkg::COARSE_LAST) ? 6'h00 : 6'(cidx_r + 6'h01);
      rd_ratio_r <= 7'(rd_ratio_r + dlts_pkg::COARSE_STEP);
    end else if (st_r == dlts_pkg::ST_SCAN) begin
      cidx_r <= 6'(cidx_r + 6'h01);
      if (scan_take && mem_q) begin
        run_len_r <= 6'(run_len_r + 6'h01);
        if (run_len_r == 6'h00) run_st_r <= 6'(pos);
        if (6'(run_len_r + 6'h01) > best_len_r) begin
          best_len_r <= 6'(run_len_r + 6'h01);
          best_st_r  <= (run_len_r == 6'h00) ? 6'(pos) : run_st_r;
        end
      end else if (scan_take) begin
        run_len_r <= 6'h00;
      end
    end else if (st_r == dlts_pkg::ST_CALC) begin
      rd_ratio_r <= f_lo;
    end else if (in_fine && rd_end && rd_ratio_r != fend_r) begin
      rd_ratio_r <= 7'(rd_ratio_r + 7'h01);
    end
  end

  // ------------------------------------------------------------------
  // temperature, optimum value, failure search and final choice
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      temp_r      <= 10'sd0;
      otv_r       <= 7'h00;
      fend_r      <= 7'h00;
      fa_r        <= 1'b0;
      fa_rat_r    <= 7'h00;
      fb_r        <= 1'b0;
      fb_rat_r    <= 7'h00;
      final_r     <= 7'h00;
      tune_done_r <= 1'b0;
      tune_fail_r <= 1'b0;
    end else begin
      if (tune_start && !tune_busy) begin
        tune_done_r <= 1'b0;
        tune_fail_r <= 1'b0;
        fa_r        <= 1'b0;
        fb_r        <= 1'b0;
      end
      if (st_r == dlts_pkg::ST_TEMP) temp_r <= temp_c;
      if (st_r == dlts_pkg::ST_CALC) begin
        otv_r  <= otv_nxt;
        fend_r <= f_hi;
      end
      if (in_fine && rd_end && !rd_pass) begin
        if (rd_ratio_r > otv_r && !fa_r) begin
          fa_r     <= 1'b1;
          fa_rat_r <= rd_ratio_r;
        end
        if (rd_ratio_r < otv_r) begin
          fb_r     <= 1'b1;
          fb_rat_r <= rd_ratio_r;
        end
      end
      if (st_r == dlts_pkg::ST_FIX) final_r <= fix_v;
      if (st_r == dlts_pkg::ST_TEMP && best_len_r == 6'h00) tune_fail_r <= 1'b1;
      if (st_nxt == dlts_pkg::ST_DONE && st_r != dlts_pkg::ST_DONE) tune_done_r <= 1'b1;
    end
  end

  assign forced_delay_ratio = final_r;
  assign delay_line_control_register = 32'(final_r) << dlts_pkg::FRC_LSB;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_coarse_step: assert property (in_coarse && rd_end && cidx_r != dlts_pkg::COARSE_LAST
    |=> rd_ratio_r == 7'($past(rd_ratio_r) + 7'h04)) else $error("coarse step not 4");
  // a crc-flagged read must leave a fail bit in the pass map
  a_pass_record: assert property (in_coarse && rd_end && rd_crc_err
    |=> !u_mem.bits_r[$past(cidx_r[4:0])]) else $error("crc failure kept as pass");
  // both ends of the chosen window must be passing coarse points
  a_window_len: assert property (st_r == dlts_pkg::ST_TEMP && best_len_r != 6'h00
    |-> u_mem.bits_r[best_st_r[4:0]] && u_mem.bits_r[5'(best_st_r + best_len_r - 6'h01)])
    else $error("window edge not passing");
  a_temp_sample: assert property (st_r == dlts_pkg::ST_TEMP
    |=> temp_r == $past(temp_c)) else $error("temperature not sampled");
  // eight bits so ratios near the top of the range do not wrap
  a_fine_range: assert property (in_fine
    |-> 8'(rd_ratio_r) + 8'h0A >= 8'(otv_r) && 8'(rd_ratio_r) <= 8'(otv_r) + 8'h0A)
    else $error("fine out of span");
  a_keep_otv: assert property (st_r == dlts_pkg::ST_FIX && !fa_r && !fb_r
    |=> final_r == otv_r) else $error("optimum value changed");
  a_move_down: assert property (st_r == dlts_pkg::ST_FIX && fa_r && !cold
    |=> final_r < fa_rat_r || final_r == 7'h00) else $error("not moved down");
  a_move_up_cold: assert property (st_r == dlts_pkg::ST_FIX && fa_r && cold
    |=> final_r > fa_rat_r || final_r == 7'h7C) else $error("not moved up");
  a_skip_low: assert property (st_r == dlts_pkg::ST_CALC && otv_nxt < 7'h28
    |=> st_r == dlts_pkg::ST_FIX ##1 st_r == dlts_pkg::ST_DONE) else $error("no skip");
  // the field must carry the value chosen in the fix cycle
  a_ratio_field: assert property ($rose(tune_done_r) && !tune_fail_r
    |-> delay_line_control_register[19:13] == $past(fix_v)) else $error("field wrong");

endmodule

/* dv/dlts_card_model.sv */
// dlts_card_model: card answering tuning reads of the read tuning sequencer
// assumes the bench sets the passing window, one failing ratio and the pacing
`timescale 1ns/100ps
module dlts_card_model #(
  parameter int BEATS = 16
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // read request from the sequencer
  input  wire logic       rd_req,
  input  wire logic [6:0] rd_ratio_r,
  // pass map and pacing set by the bench
  input  wire logic [6:0] win_lo,
  input  wire logic [6:0] win_hi,
  input  wire logic [6:0] rt_ratio,
  input  wire logic       rt_crc,
  input  wire logic       slow,
  // returned block
  output logic            rd_beat,
  output logic [7:0]      rd_data,
  output logic [7:0]      rd_expect,
  output logic            rd_end,
  output logic            rd_crc_err
);
  logic bad;  // current ratio reads back wrong
  int   i;    // beat index

  initial begin
    rd_beat    = 1'h0;
    rd_data    = 8'h00;
    rd_expect  = 8'hFF;
    rd_end     = 1'h0;
    rd_crc_err = 1'h0;
  end

  // ------------------------------------------------------------------
  // one tuning read: beats, one quiet cycle (two when slow), end pulse, then a gap
  // ------------------------------------------------------------------
  always begin
    @(posedge clk_sys);
    if (rst || rd_req !== 1'h1) begin
      // released lines keep toggling so no stale byte survives
      rd_data    <= ~rd_data;
      rd_expect  <= ~rd_expect;
      rd_beat    <= 1'h0;
      rd_end     <= 1'h0;
      rd_crc_err <= 1'h0;
    end else begin
      bad = rd_ratio_r < win_lo || rd_ratio_r > win_hi || rd_ratio_r == rt_ratio;
      for (i = 0; i < BEATS; i++) begin
        rd_beat   <= 1'h1;
        rd_expect <= 8'hA5 ^ 8'(i);
        // a failing read spoils only the last byte unless crc reports it
        rd_data   <= 8'hA5 ^ 8'(i) ^ {7'h00, bad && !rt_crc && i == BEATS - 1};
        @(posedge clk_sys);
        // lower the strobe only where a gap follows, never twice in one edge
        if (slow || i == BEATS - 1) begin
          rd_beat   <= 1'h0;
          rd_data   <= ~rd_data;
          rd_expect <= ~rd_expect;
        end
        if (slow) begin
          @(posedge clk_sys);
        end
      end
      @(posedge clk_sys);
      rd_end     <= 1'h1;
      rd_crc_err <= bad && rt_crc;
      @(posedge clk_sys);
      rd_end     <= 1'h0;
      rd_crc_err <= 1'h0;
      // let the next ratio land before it is sampled
      @(posedge clk_sys);
    end
  end
endmodule

/* dv/dlts_seq_bench.sv */
// dlts_seq_bench: self-checking bench for the delay-line read tuning sequencer
// assumes the card model answers every read; rows hold the plain tuning runs
`timescale 1ns/100ps
module dlts_seq_bench;
  // ------------------------------------------------------------------
  // signals and rows
  // ------------------------------------------------------------------
  typedef struct packed {
    logic signed [9:0] temp;    // on-die temperature
    logic [6:0]        rt;      // single failing ratio, 7F for none
    logic              crc;     // failures shown by crc flag only
    logic [3:0]        margin;  // downward margin
    logic [6:0]        optimum_tuning_value;     // expected optimum value
    logic [6:0]        fin;     // expected final ratio
  } dlts_row_t;
  logic              clk_sys, rst, tune_start, rt_crc, slow;
  logic [3:0]        retime_margin;
  logic signed [9:0] temp_c;
  logic [6:0]        win_lo, win_hi, rt_ratio, rd_ratio_r, forced_delay_ratio;
  logic              tune_busy, tune_done_r, tune_fail_r, rd_req;
  logic              rd_beat, rd_end, rd_crc_err;
  logic [7:0]        rd_data, rd_expect;
  logic [31:0]       delay_line_control_register;
  int                error_cnt, num_checks, nread, fine_lo, k;
  // window 20..116 throughout; temperatures sit on or one below band edges, or at 25
  dlts_row_t rows [16] = '{
    '{10'h3EB, 7'h7F, 1'h0, 4'h8, 7'h5C, 7'h5C},
    '{10'h3EC, 7'h7F, 1'h0, 4'h8, 7'h4A, 7'h4A},
    '{10'h014, 7'h47, 1'h0, 4'h8, 7'h44, 7'h3F},
    '{10'h014, 7'h47, 1'h0, 4'hF, 7'h44, 7'h38},
    '{10'h028, 7'h37, 1'h0, 4'h8, 7'h3E, 7'h3F},
    '{10'h046, 7'h29, 1'h1, 4'h8, 7'h32, 7'h33},
    '{10'h05A, 7'h27, 1'h0, 4'h8, 7'h2C, 7'h33},
    '{10'h078, 7'h29, 1'h0, 4'h8, 7'h26, 7'h26},
    '{10'h3EB, 7'h5F, 1'h0, 4'h8, 7'h5C, 7'h6B},
    '{10'h009, 7'h45, 1'h0, 4'h8, 7'h4A, 7'h51},
    '{10'h00A, 7'h45, 1'h0, 4'h8, 7'h4A, 7'h4D},
    '{10'h019, 7'h4E, 1'h0, 4'h8, 7'h44, 7'h46},
    '{10'h019, 7'h4F, 1'h0, 4'h8, 7'h44, 7'h44},
    '{10'h019, 7'h3A, 1'h0, 4'h8, 7'h44, 7'h42},
    '{10'h019, 7'h39, 1'h0, 4'h8, 7'h44, 7'h44},
    '{10'h019, 7'h2C, 1'h1, 4'h8, 7'h52, 7'h52}
  };

  dlts_seq uut (
    .clk_sys(clk_sys), .rst(rst), .tune_start(tune_start), .retime_margin(retime_margin),
    .temp_c(temp_c), .tune_busy(tune_busy), .tune_done_r(tune_done_r),
    .tune_fail_r(tune_fail_r), .rd_req(rd_req), .rd_ratio_r(rd_ratio_r), .rd_beat(rd_beat),
    .rd_data(rd_data), .rd_expect(rd_expect), .rd_end(rd_end), .rd_crc_err(rd_crc_err),
    .delay_line_control_register(delay_line_control_register),
    .forced_delay_ratio(forced_delay_ratio));
  dlts_card_model card (
    .clk_sys(clk_sys), .rst(rst), .rd_req(rd_req), .rd_ratio_r(rd_ratio_r),
    .win_lo(win_lo), .win_hi(win_hi), .rt_ratio(rt_ratio), .rt_crc(rt_crc), .slow(slow),
    .rd_beat(rd_beat), .rd_data(rd_data), .rd_expect(rd_expect), .rd_end(rd_end),
    .rd_crc_err(rd_crc_err));

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  // ------------------------------------------------------------------
  // compares, run and close
  // ------------------------------------------------------------------
  task automatic chkb(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chkw(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // start one run and wait, bounded, for it to finish
  task automatic run_tune(input logic signed [9:0] t, input logic [3:0] m);
    int n;
    nread = 0;
    @(posedge clk_sys);
    temp_c        <= t;
    retime_margin <= m;
    tune_start    <= 1'h1;
    @(posedge clk_sys);
    tune_start <= 1'h0;
    @(posedge clk_sys);
    chkb("busy in run", 1'h1, tune_busy);
    chkb("done cleared", 1'h0, tune_done_r);
    n = 0;
    while (tune_done_r !== 1'h1 && tune_fail_r !== 1'h1 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    #1;
    if (n == 4000) begin
      error_cnt++;
      $display("Error tune run expected finish seen busy");
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // every finished read must carry the ratio of its place in the order
  always @(posedge clk_sys) begin
    if (rd_end === 1'h1 && rd_req === 1'h1 && rst === 1'h0) begin
      chkw("read ratio", nread < 32 ? 32'(4 * nread) : 32'(fine_lo + nread - 32), {25'h0, rd_ratio_r});
      nread++;
    end
  end

  // watchdog: about twice the expected run length
  initial begin
    #1200000;
    error_cnt++;
    $display("Error watchdog expected finish seen hang");
    close_out();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    clk_sys = 1'h0; rst = 1'h1; tune_start = 1'h0; retime_margin = 4'h8; temp_c = 10'h019;
    win_lo = 7'h14; win_hi = 7'h74; rt_ratio = 7'h7F; rt_crc = 1'h0; slow = 1'h0;
    error_cnt = 0; num_checks = 0; nread = 0; fine_lo = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    #1;
    chkb("busy", 1'h0, tune_busy);
    chkb("req", 1'h0, rd_req);
    chkw("control word", 32'h0, delay_line_control_register);
    $display("test reset done");
    for (k = 0; k < 16; k++) begin
      rt_ratio <= rows[k].rt;
      rt_crc   <= rows[k].crc;
      slow     <= k[0];
      fine_lo = int'(rows[k].optimum_tuning_value) - 10;
      run_tune(rows[k].temp, rows[k].margin);
      chkb("done", 1'h1, tune_done_r);
      chkb("fail flag", 1'h0, tune_fail_r);
      chkw("final ratio", {25'h0, rows[k].fin}, {25'h0, forced_delay_ratio});
      chkw("control word", {12'h0, rows[k].fin, 13'h0}, delay_line_control_register);
      chkb("search skipped", rows[k].optimum_tuning_value < 7'h28, nread == 32);
      $display("test row %0d done", k);
    end
    // nothing passes: run fails and the last ratio stays
    win_lo <= 7'h7F;
    win_hi <= 7'h00;
    run_tune(10'h019, 4'h8);
    chkb("fail flag", 1'h1, tune_fail_r);
    chkw("kept ratio", 32'h52, {25'h0, forced_delay_ratio});
    chkb("all coarse reads", 1'h1, nread == 32);
    $display("test no window done");
    // reset in mid sweep, then a full run again
    win_lo <= 7'h14;
    win_hi <= 7'h74;
    rt_ratio <= 7'h7F;
    rt_crc <= 1'h0;
    nread = 0;
    @(posedge clk_sys);
    tune_start <= 1'h1;
    @(posedge clk_sys);
    tune_start <= 1'h0;
    repeat (300) @(posedge clk_sys);
    rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    #1;
    chkb("busy in reset", 1'h0, tune_busy);
    chkb("req in reset", 1'h0, rd_req);
    chkb("done in reset", 1'h0, tune_done_r);
    chkw("ratio in reset", 32'h0, {25'h0, forced_delay_ratio});
    @(posedge clk_sys);
    rst <= 1'h0;
    repeat (60) @(posedge clk_sys);
    fine_lo = 82;
    run_tune(10'h3EB, 4'h8);
    chkw("ratio after reset", 32'h5C, {25'h0, forced_delay_ratio});
    $display("test mid reset done");
    close_out();
  end
endmodule
